// ===== core/clkq_defs.svh
// register map, field positions, reset values and limits of the strobe block
`ifndef CLKQ_DEFS_SVH
`define CLKQ_DEFS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_QUAL        4'h4
`define REG_SYNCWAIT    4'h8
`define REG_STATUS      4'hc

// ==========================================================================
// control register fields
`define CTRL_CUSTOM_QUAL  0
`define CTRL_EDGE_SEL     1
`define CTRL_CUSTOM_SYN   2
`define CTRL_DIVIDE       3
`define CTRL_CNT_LO       4
`define CTRL_CNT_HI       6
`define CTRL_RESET        32'h0000_0000

// ==========================================================================
// qualifier register: condition bits low, care bits from bit 8
`define QUAL_POL_LO       0
`define QUAL_CARE_LO      8
`define QUAL_RESET        32'h0000_0000

// ==========================================================================
// sync and wait settings, two bits each: {care, active_high}
`define SW_SYNC_A         0
`define SW_SYNC_B         2
`define SW_WAIT_A         4
`define SW_WAIT_B         6
`define SW_RESET          32'h0000_0000

// ==========================================================================
// status register fields
`define ST_STATE_LO       16
`define ST_WAIT           18
`define ST_SYNC           19

// ==========================================================================
// synthesis count limits
`define CNT_MAX           3'h4
`define DIV_MIN           3'h1
`endif

// ===== core/clkq_pkg.sv
// types shared by the strobe block
package clkq_pkg;
  // gray coded along idle -> delay count -> divide run
  typedef enum logic [1:0] {
    SYN_IDLE  = 2'b00,
    SYN_DELAY = 2'b01,
    SYN_RUN   = 2'b11
  } syn_state_e;
endpackage : clkq_pkg

// ===== core/state_clock_qualifier_synthesizer.sv
// state strobe qualifier and synthesizer with avalon-mm register access
//
// Summary of operation
// - strobes appear only on master clock edges, rejected edges dropped
// - edge select 0 picks rising, 1 picks falling master clock edge
// - qualifier line group conditions are ANDed to pass an edge
// - without custom qualification, rising edge and no qualifiers apply
// - standard synthesis passes each qualified edge straight through
// - delay mode strobes 0 to 4 edges after sync becomes true
// - delay mode gives one strobe per sync becoming true outside a running delay
// - divide mode divides qualified edges by 1 to 4 after sync
// - divide mode restarts the division whenever sync becomes true
// - sync is OR of two lines, each low, high or ignored
// - delay mode with both sync lines ignored never strobes
// - divide mode with both sync lines ignored has no defined pattern
// - in delay and divide modes each edge with wait asserted adds one edge before the strobe
// - wait is OR of two lines, each low, high or ignored
// - sync is suspended while wait is asserted
// - settings persist until rewritten; only reset restores defaults
// - the same strobe feeds the timing capture in synchronous mode
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`include "clkq_defs.svh"

module state_clock_qualifier_synthesizer #(
  parameter int QUAL_LINES = 6,
  parameter int CNT_W      = 16
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [3:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  input  wire logic                  master_clk_in,
  input  wire logic [QUAL_LINES-1:0] qualifier_line_group_in,
  input  wire logic                  sync_line_a_in,
  input  wire logic                  sync_line_b_in,
  input  wire logic                  wait_line_a_in,
  input  wire logic                  wait_line_b_in,
  input  wire logic                  timing_sync_mode_in,
  output logic                       state_strobe_out,
  output logic                       timing_strobe_out
);

  if (QUAL_LINES < 1 || QUAL_LINES > 8 || CNT_W < 1 || CNT_W > 16)
  begin : g_bad_params
    $error("qualifier lines must be 1..8 and count width 1..16");
  end

  // ========================================================================
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire logic rstn = rst_sync_q;

  // ========================================================================
  // register bus
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] qual_q, qual_d;
  logic [31:0] sw_q, sw_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic        busy_q, busy_d;
  logic [31:0] status;

  always_comb
  begin
    ack_d   = (avs_read_in || avs_write_in) && !ack_q;
    busy_d  = !ack_d;
    rdata_d = rdata_q;
    ctrl_d  = ctrl_q;
    qual_d  = qual_q;
    sw_d    = sw_q;
    if (ack_d)
    begin
      case (avs_address_in)
        `REG_CTRL:     rdata_d = ctrl_q;
        `REG_QUAL:     rdata_d = qual_q;
        `REG_SYNCWAIT: rdata_d = sw_q;
        `REG_STATUS:   rdata_d = status;
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
    // settings change only by a write or by reset, which loads the reset values
    if (ack_q && avs_write_in)
    begin
      case (avs_address_in)
        `REG_CTRL:     ctrl_d = avs_writedata_in;
        `REG_QUAL:     qual_d = avs_writedata_in;
        `REG_SYNCWAIT: sw_d   = avs_writedata_in;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_q   <= 1'b0;
      busy_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= `CTRL_RESET;
      qual_q  <= `QUAL_RESET;
      sw_q    <= `SW_RESET;
    end
    else
    begin
      ack_q   <= ack_d;
      busy_q  <= busy_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      qual_q  <= qual_d;
      sw_q    <= sw_d;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = busy_q;

  // ========================================================================
  // settings decode
  wire logic       custom_qual = ctrl_q[`CTRL_CUSTOM_QUAL];
  wire logic       custom_syn  = ctrl_q[`CTRL_CUSTOM_SYN];
  wire logic       divide_mode = ctrl_q[`CTRL_DIVIDE];
  wire logic [2:0] cnt_raw     = ctrl_q[`CTRL_CNT_HI:`CTRL_CNT_LO];
  logic      [2:0] cnt_set;
  logic      [2:0] ratio;

  always_comb
  begin
    cnt_set = (cnt_raw > `CNT_MAX) ? `CNT_MAX : cnt_raw;
    ratio   = (cnt_set < `DIV_MIN) ? `DIV_MIN : cnt_set;
  end

  // a line pair gives a level: ignored lines drop out of the OR
  function automatic logic line_or(input logic [3:0] cfg,
                                   input logic       a,
                                   input logic       b);
    logic hit_a;
    logic hit_b;
    hit_a = cfg[1] && (a == cfg[0]);
    hit_b = cfg[3] && (b == cfg[2]);
    return hit_a || hit_b;
  endfunction : line_or

  wire logic sync_on = line_or(sw_q[`SW_SYNC_B+1:`SW_SYNC_A],
                               sync_line_a_in, sync_line_b_in);
  wire logic wait_on = line_or(sw_q[`SW_WAIT_B+1:`SW_WAIT_A],
                               wait_line_a_in, wait_line_b_in);
  wire logic sync_cared = sw_q[`SW_SYNC_A+1] || sw_q[`SW_SYNC_B+1];

  // ========================================================================
  // edge selection and qualification
  logic mclk_q;
  logic edge_fall;
  logic and_ok;
  logic qual_edge;

  always_comb
  begin
    edge_fall = custom_qual && ctrl_q[`CTRL_EDGE_SEL];
    and_ok    = 1'b1;
    for (int i = 0; i < QUAL_LINES; i++)
    begin
      if (custom_qual && qual_q[`QUAL_CARE_LO+i] &&
          (qualifier_line_group_in[i] != qual_q[`QUAL_POL_LO+i]))
        and_ok = 1'b0;
    end
    qual_edge = and_ok && (edge_fall ? (mclk_q && !master_clk_in)
                                     : (!mclk_q && master_clk_in));
  end

  // ========================================================================
  // synthesis: runs only on qualified edges
  clkq_pkg::syn_state_e st_q, st_d;
  logic [2:0]       cnt_q, cnt_d;
  logic             sync_prev_q, sync_prev_d;
  logic             strobe_q, strobe_d;
  logic [CNT_W-1:0] nstrobe_q, nstrobe_d;
  logic             sync_hit;
  logic             tstrobe_q, tstrobe_d;

  always_comb
  begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    sync_prev_d = sync_prev_q;
    strobe_d    = 1'b0;
    nstrobe_d   = nstrobe_q;
    // wait suspends sync
    sync_hit    = sync_on && !sync_prev_q && !wait_on;
    if (qual_edge)
    begin
      sync_prev_d = sync_on;
      if (!custom_syn)
      begin
        strobe_d = 1'b1;
        st_d     = clkq_pkg::SYN_IDLE;
      end
      else if (wait_on)
      begin
        // edge spent as a wait cycle: nothing advances
        st_d = st_q;
      end
      else if (!divide_mode)
      begin
        case (st_q)
          clkq_pkg::SYN_DELAY:
          begin
            // one strobe per sync: later syncs are ignored meanwhile
            if (cnt_q == 3'h1)
            begin
              strobe_d = 1'b1;
              st_d     = clkq_pkg::SYN_IDLE;
            end
            cnt_d = cnt_q - 3'h1;
          end
          default:
          begin
            st_d = clkq_pkg::SYN_IDLE;
            if (sync_hit && sync_cared)
            begin
              if (cnt_set == 3'h0)
                strobe_d = 1'b1;
              else
              begin
                st_d  = clkq_pkg::SYN_DELAY;
                cnt_d = cnt_set;
              end
            end
          end
        endcase
      end
      else
      begin
        // divide: sync restarts the phase, strobing on that edge
        if (sync_hit)
        begin
          strobe_d = 1'b1;
          st_d     = clkq_pkg::SYN_RUN;
          cnt_d    = ratio - 3'h1;
        end
        else if (st_q == clkq_pkg::SYN_RUN)
        begin
          if (cnt_q == 3'h0)
          begin
            strobe_d = 1'b1;
            cnt_d    = ratio - 3'h1;
          end
          else
            cnt_d = cnt_q - 3'h1;
        end
        else
          st_d = clkq_pkg::SYN_IDLE;
      end
    end
    if (strobe_d)
      nstrobe_d = nstrobe_q + 1'b1;
    tstrobe_d = strobe_d && timing_sync_mode_in;
  end

  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      mclk_q      <= 1'b0;
      st_q        <= clkq_pkg::SYN_IDLE;
      cnt_q       <= 3'h0;
      sync_prev_q <= 1'b0;
      strobe_q    <= 1'b0;
      nstrobe_q   <= '0;
      tstrobe_q   <= 1'b0;
    end
    else
    begin
      mclk_q      <= master_clk_in;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      sync_prev_q <= sync_prev_d;
      strobe_q    <= strobe_d;
      nstrobe_q   <= nstrobe_d;
      tstrobe_q   <= tstrobe_d;
    end
  end

  assign state_strobe_out  = strobe_q;
  assign timing_strobe_out = tstrobe_q;

  always_comb
  begin
    status = 32'h0000_0000;
    status[CNT_W-1:0] = nstrobe_q;
    status[`ST_STATE_LO+1:`ST_STATE_LO] = st_q;
    status[`ST_WAIT] = wait_on;
    status[`ST_SYNC] = sync_on;
  end

  // ========================================================================
  // checks
  sequence s_delay0_sync;
    custom_syn && !divide_mode && cnt_set == 3'h0 && st_q ==
      clkq_pkg::SYN_IDLE && qual_edge && !wait_on && sync_hit && sync_cared;
  endsequence

  chk_strobe_on_edge: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) state_strobe_out |-> $past(qual_edge))
    else $error("strobe without a qualified master clock edge");

  chk_edge_polarity: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) qual_edge |-> (edge_fall ? $fell(master_clk_in)
                                               : $rose(master_clk_in)))
    else $error("qualified edge of the wrong polarity");

  chk_and_gate: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) qual_edge && custom_qual |->
      (((qualifier_line_group_in ^ qual_q[QUAL_LINES-1:0]) &
        qual_q[`QUAL_CARE_LO+QUAL_LINES-1:`QUAL_CARE_LO]) == '0))
    else $error("edge passed with a qualifier line false");

  chk_default_qual: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) !custom_qual && !mclk_q && master_clk_in |->
      qual_edge)
    else $error("default rising edge was not passed");

  chk_standard_pass: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) !custom_syn && qual_edge |=> state_strobe_out)
    else $error("standard synthesis dropped an edge");

  chk_zero_delay: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) s_delay0_sync |=> state_strobe_out)
    else $error("zero delay strobe missing");

  chk_no_sync_none: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) custom_syn && !divide_mode && !sync_cared &&
      st_q == clkq_pkg::SYN_IDLE |=> !state_strobe_out)
    else $error("delay mode strobed with sync ignored");

  chk_wait_hold: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) custom_syn && wait_on && qual_edge |=>
      !state_strobe_out && $stable(st_q) && $stable(cnt_q))
    else $error("wait edge advanced the synthesis");

  chk_divide_restart: assert property (@(posedge ref_clk_in)
    disable iff (!rstn) custom_syn && divide_mode && qual_edge &&
      sync_hit |=> state_strobe_out && cnt_q == $past(ratio) - 3'h1)
    else $error("sync did not restart the division");

endmodule : state_clock_qualifier_synthesizer

// ===== test/target_sys_model.sv
// target system model: master clock that stands low outside runs
module target_sys_model #(
  parameter int HALF = 5
) (
  input  wire logic ref_clk_in,
  input  wire logic run_in,
  output logic      master_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt_q = 0;

  initial master_clk_out = 1'h0;

  // ==========================================================================
  // master clock
  // each phase lasts HALF ref cycles; a high phase always completes
  always @(posedge ref_clk_in)
  begin
    if (run_in || master_clk_out)
    begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1)
        master_clk_out <= ~master_clk_out;
    end
    else
      cnt_q <= 0;
  end
endmodule : target_sys_model

// ===== test/state_clock_qualifier_synthesizer_tb_top.sv
// testbench of the state strobe qualifier and synthesizer
module state_clock_qualifier_synthesizer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'h0;
  logic        rstn    = 1'h0;
  logic [3:0]  addr    = 4'h0;
  logic        rd      = 1'h0;
  logic        wr      = 1'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic        mclk;
  logic        run_q   = 1'h0;
  logic [5:0]  qual    = 6'h0;
  logic        sa      = 1'h0;
  logic        sb      = 1'h0;
  logic        wa      = 1'h0;
  logic        wb      = 1'h0;
  logic        tmode   = 1'h0;
  logic        sstb;
  logic        tstb;
  logic [15:0] sm;
  logic [15:0] tmk;
  logic        bad;
  logic        fl      = 1'h0;
  logic [31:0] q;
  int          idx     = 0;
  int          err_total  = 0;
  int          num_checks = 0;

  initial forever #2.5 ref_clk = ~ref_clk;

  state_clock_qualifier_synthesizer dut_u (
    .ref_clk_in              (ref_clk),
    .rstn_in                 (rstn),
    .avs_address_in          (addr),
    .avs_read_in             (rd),
    .avs_write_in            (wr),
    .avs_writedata_in        (wdat),
    .avs_readdata_out        (rdat),
    .avs_waitrequest_out     (wreq),
    .master_clk_in           (mclk),
    .qualifier_line_group_in (qual),
    .sync_line_a_in          (sa),
    .sync_line_b_in          (sb),
    .wait_line_a_in          (wa),
    .wait_line_b_in          (wb),
    .timing_sync_mode_in     (tmode),
    .state_strobe_out        (sstb),
    .timing_strobe_out       (tstb)
  );

  target_sys_model target_u (
    .ref_clk_in     (ref_clk),
    .run_in         (run_q),
    .master_clk_out (mclk)
  );

  // ==========================================================================
  // strobe monitor: strobe lands in the slot of the last active edge
  always @(posedge ref_clk)
  begin
    if (sstb === 1'h1)
    begin
      sm[idx] = 1'h1;
      if (mclk !== ~fl)
        bad = 1'h1;
    end
    if (tstb === 1'h1)
      tmk[idx] = 1'h1;
  end

  // ==========================================================================
  // helpers
  task automatic end_of_test;
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic do_reset;
    @(posedge ref_clk);
    rstn <= 1'h0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset

  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    addr <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    // only the watchdog ends a wait that never gets an answer
    do
      @(posedge ref_clk);
    while (wreq !== 1'h0);
    r = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : av

  // expected strobe slots from control word, line enables and vectors
  function automatic logic [15:0] exp_mask(input logic [6:0] c,
    input logic en, input logic [15:0] qv, sv, wv);
    logic [15:0] m;
    logic [2:0]  n;
    logic [2:0]  k;
    logic        act;
    logic        p;
    logic        s;
    logic        r;
    m = 16'h0;
    n = (c[6:4] > 3'h4) ? 3'h4 : c[6:4];
    if (c[3] && n == 3'h0)
      n = 3'h1;
    act = 1'h0;
    p = 1'h0;
    k = 3'h0;
    for (int i = 0; i < 16; i++)
      if (!c[0] || qv[i])
      begin
        // previous sync level is taken on every qualified edge
        s = en & sv[i];
        r = s && !p && !(en & wv[i]);
        p = s;
        if (!c[2])
          m[i] = 1'h1;
        else if (!(en & wv[i]))
        begin
          if (act && !(c[3] && r))
          begin
            k = k - 3'h1;
            m[i] = (k == 3'h0);
            act = (k != 3'h0) || c[3];
            if (c[3] && k == 3'h0)
              k = n;
          end
          else if (r)
          begin
            m[i] = c[3] || n == 3'h0;
            act = c[3] || n != 3'h0;
            k = n;
          end
        end
      end
    return m;
  endfunction : exp_mask

  // one run of 16 active master edges with per-edge line vectors
  task automatic run(input logic [6:0] c, input logic en,
    input logic [1:0] ls, input logic fall, input logic tm,
    input logic [15:0] qv, sv, wv);
    logic [15:0] e;
    logic [7:0]  sw;
    e = exp_mask(c, en, qv, sv, wv);
    sw = (ls[1] ? 8'h80 : 8'h30) | (ls[0] ? 8'h08 : 8'h03);
    do_reset();
    av(1'h1, 4'h0, {25'h0, c}, q);
    av(1'h1, 4'h4, 32'h0000_0301, q);
    av(1'h1, 4'h8, {24'h0, en ? sw : 8'h00}, q);
    sm = 16'h0;
    tmk = 16'h0;
    bad = 1'h0;
    fl = fall;
    tmode <= tm;
    run_q <= 1'h1;
    for (int i = 0; i < 16; i++)
    begin
      while (mclk !== fall)
        @(posedge ref_clk);
      @(posedge ref_clk);
      qual <= qv[i] ? 6'h01 : 6'h03;
      sa <= ls[0] ? i[0] : sv[i];
      sb <= ls[0] ? ~sv[i] : i[0];
      wa <= ls[1] ? i[0] : wv[i];
      wb <= ls[1] ? ~wv[i] : i[0];
      while (mclk !== ~fall)
        @(posedge ref_clk);
      idx = i;
    end
    run_q <= 1'h0;
    repeat (12) @(posedge ref_clk);
    cmp({16'h0, sm}, {16'h0, e});
    cmp({16'h0, tmk}, {16'h0, tm ? e : 16'h0});
    cmp({31'h0, bad}, 32'h0);
    av(1'h0, 4'hc, 32'h0, q);
    cmp({16'h0, q[15:0]}, $countones(e));
    av(1'h0, 4'h0, 32'h0, q);
    cmp(q, {25'h0, c});
  endtask : run

  // ==========================================================================
  // tests
  initial
  begin
    do_reset();
    av(1'h1, 4'h1, 32'hffff_ffff, q);
    av(1'h1, 4'hc, 32'hffff_ffff, q);
    for (int a = 0; a < 16; a++)
    begin
      av(1'h0, a[3:0], 32'h0, q);
      cmp(q, 32'h0);
    end
    run(7'h00, 1'h1, 2'h0, 1'h0, 1'h1, 16'h5a5a, 16'h0, 16'h00f0);
    run(7'h01, 1'h1, 2'h0, 1'h0, 1'h0, 16'h5a5a, 16'h0, 16'h0);
    run(7'h03, 1'h1, 2'h0, 1'h1, 1'h1, 16'h0ff0, 16'h0, 16'h0);
    for (int n = 0; n < 5; n++)
      run(7'h05 | 7'(n << 4), 1'h1, {1'h0, n[0]}, 1'h0, 1'h1,
          16'hfeff, 16'h0820, 16'h0);
    run(7'h25, 1'h0, 2'h0, 1'h0, 1'h0, 16'hffff, 16'h0820, 16'h0);
    for (int r = 1; r < 5; r++)
      run(7'h0d | 7'(r << 4), 1'h1, r[1:0], 1'h0, 1'h0,
          16'hffff, 16'h0202, 16'h0);
    for (int l = 0; l < 4; l++)
      run(7'h25, 1'h1, l[1:0], 1'h0, 1'h0,
          16'hffff, 16'h0002, 16'h0004);
    run(7'h4d, 1'h1, 2'h2, 1'h0, 1'h0, 16'hffff, 16'h0022, 16'h0020);
    end_of_test();
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
endmodule : state_clock_qualifier_synthesizer_tb_top
